// ===== rtl/fli_top.v
// fieldbus led indicator driver with apb registers
`timescale 1ns/1ps
`include "fli_regs.vh"
module fli_top #(
    parameter TICK_DIV = `FLI_TICK_PER_MS
) (
    // clock and reset
    input wire CLK,
    input wire NRST,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    // per port link and activity pins
    input wire PORT_IN_LINK,
    input wire PORT_IN_ACT,
    input wire PORT_OUT_LINK,
    input wire PORT_OUT_ACT,
    // led outputs
    output reg PORT_IN_LINK_INDICATOR,
    output reg PORT_OUT_LINK_INDICATOR,
    output reg STATE_INDICATOR,
    // two-wire serial data line carrying the red indicator
    input wire SDA_I,
    output reg SDA_O,
    output reg SDA_OE,
    // interrupt
    output reg IRQ
);
    // ======================================================
    // input synchronisers
    reg [3:0] pin_s1_q;
    reg [3:0] pin_s2_q;
    always @(posedge CLK) begin
        if (!NRST) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
        end else begin
            pin_s1_q <= {PORT_OUT_ACT, PORT_OUT_LINK, PORT_IN_ACT, PORT_IN_LINK};
            pin_s2_q <= pin_s1_q;
        end
    end

    // ======================================================
    // 1 ms tick divider
    reg [31:0] div_q;
    reg ms_tick_q;
    always @(posedge CLK) begin
        if (!NRST) begin
            div_q <= 32'h0000_0000;
            ms_tick_q <= 1'b0;
        end else if (div_q == TICK_DIV - 1) begin
            div_q <= 32'h0000_0000;
            ms_tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 32'h0000_0001;
            ms_tick_q <= 1'b0;
        end
    end

    wire flicker;
    wire blink;
    wire single;
    wire double;
    fli_pattern u_pat (
        .CLK(CLK),
        .NRST(NRST),
        .ms_tick(ms_tick_q),
        .flicker(flicker),
        .blink(blink),
        .single(single),
        .double(double)
    );

    // ======================================================
    // registers
    reg [31:0] ctrl_q;
    reg [3:0] err_q;
    reg [3:0] irq_q;
    reg [3:0] mask_q;
    reg [3:0] err_prev_q;
    wire wr_en = PSEL && PENABLE && PWRITE && PREADY;
    wire rd_en = PSEL && !PENABLE && !PWRITE;
    wire [2:0] slave_state = ctrl_q[`FLI_CTRL_STATE_MSB:`FLI_CTRL_STATE_LSB];
    wire change_err = ctrl_q[`FLI_CTRL_CHANGE_MSB:`FLI_CTRL_CHANGE_LSB] == `FLI_CHANGE_ERR;
    wire [3:0] err_rise = err_q & ~err_prev_q;
    wire hit = PADDR == `FLI_CTRL_OFF || PADDR == `FLI_STAT_OFF || PADDR == `FLI_IRQ_OFF ||
               PADDR == `FLI_MASK_OFF || PADDR == `FLI_ERR_OFF;

    // apb handshake: no wait state, ready in first access cycle
    always @(posedge CLK) begin
        if (!NRST) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !hit;
        end
    end

    // writable registers
    always @(posedge CLK) begin
        if (!NRST) begin
            ctrl_q <= `FLI_CTRL_RST;
            err_q <= 4'h0;
            mask_q <= 4'h0;
        end else if (wr_en) begin
            if (PADDR == `FLI_CTRL_OFF)
                ctrl_q <= PWDATA & 32'h0000_FF07;
            if (PADDR == `FLI_ERR_OFF)
                err_q <= PWDATA[3:0];
            if (PADDR == `FLI_MASK_OFF)
                mask_q <= PWDATA[3:0];
        end
    end

    // sticky status: rising error condition sets, write one clears, set wins
    always @(posedge CLK) begin
        if (!NRST) begin
            irq_q <= 4'h0;
            err_prev_q <= 4'h0;
            IRQ <= 1'b0;
        end else begin
            err_prev_q <= err_q;
            if (wr_en && PADDR == `FLI_IRQ_OFF)
                irq_q <= (irq_q & ~PWDATA[3:0]) | err_rise;
            else
                irq_q <= irq_q | err_rise;
            IRQ <= |(irq_q & mask_q);
        end
    end

    // read data registered in setup phase
    always @(posedge CLK) begin
        if (!NRST) begin
            PRDATA <= 32'h0000_0000;
        end else if (rd_en) begin
            case (PADDR)
                `FLI_CTRL_OFF: PRDATA <= ctrl_q;
                `FLI_STAT_OFF: PRDATA <= {26'h000_0000, SDA_O, STATE_INDICATOR,
                                          pin_s2_q};
                `FLI_IRQ_OFF: PRDATA <= {28'h000_0000, irq_q};
                `FLI_MASK_OFF: PRDATA <= {28'h000_0000, mask_q};
                `FLI_ERR_OFF: PRDATA <= {28'h000_0000, err_q};
                default: PRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // ======================================================
    // activity stretch so short traffic bursts stay visible
    localparam [5:0] ACT_HOLD = `FLI_ACT_HOLD_MS;
    reg [5:0] act_in_q;
    reg [5:0] act_out_q;
    always @(posedge CLK) begin
        if (!NRST) begin
            act_in_q <= 6'h00;
            act_out_q <= 6'h00;
        end else begin
            if (pin_s2_q[1])
                act_in_q <= ACT_HOLD;
            else if (ms_tick_q && act_in_q != 6'h00)
                act_in_q <= act_in_q - 6'h01;
            if (pin_s2_q[3])
                act_out_q <= ACT_HOLD;
            else if (ms_tick_q && act_out_q != 6'h00)
                act_out_q <= act_out_q - 6'h01;
        end
    end

    // ======================================================
    // led drive
    reg state_d;
    reg red_d;
    always @* begin
        case (slave_state)
            `FLI_ST_OP: state_d = 1'b1;
            `FLI_ST_PREOP: state_d = blink;
            `FLI_ST_SAFEOP: state_d = single;
            `FLI_ST_BOOT, `FLI_ST_BOOTSTRAP, `FLI_ST_FWDL: state_d = flicker;
            `FLI_ST_INIT: state_d = 1'b0;
            default: state_d = 1'b0;
        endcase
        // severity order: pdi watchdog, app watchdog, boot error, auto change, config
        if (err_q[`FLI_ERR_PDI])
            red_d = 1'b1;
        else if (err_q[`FLI_ERR_APPWD])
            red_d = double;
        else if (change_err && slave_state == `FLI_ST_INIT)
            red_d = flicker;
        else if (change_err || err_q[`FLI_ERR_AUTO])
            red_d = single;
        else if (err_q[`FLI_ERR_CFG])
            red_d = blink;
        else
            red_d = 1'b0;
    end

    always @(posedge CLK) begin
        if (!NRST) begin
            PORT_IN_LINK_INDICATOR <= 1'b0;
            PORT_OUT_LINK_INDICATOR <= 1'b0;
            STATE_INDICATOR <= 1'b0;
            SDA_O <= 1'b0;
            SDA_OE <= 1'b0;
        end else begin
            PORT_IN_LINK_INDICATOR <= pin_s2_q[0] && (act_in_q == 6'h00 || flicker);
            PORT_OUT_LINK_INDICATOR <= pin_s2_q[2] && (act_out_q == 6'h00 || flicker);
            STATE_INDICATOR <= state_d;
            SDA_O <= red_d;
            SDA_OE <= 1'b1;
        end
    end
endmodule // fli_top

// ===== rtl/fli_regs.vh
// register offsets, fields, reset values and timing counts of the fieldbus led indicator
`ifndef FLI_REGS_VH
`define FLI_REGS_VH

// ======================================================
// apb register byte offsets
`define FLI_CTRL_OFF 12'h000
`define FLI_STAT_OFF 12'h004
`define FLI_IRQ_OFF 12'h008
`define FLI_MASK_OFF 12'h00C
`define FLI_ERR_OFF 12'h010

// ======================================================
// control register fields
`define FLI_CTRL_STATE_LSB 0
`define FLI_CTRL_STATE_MSB 2
`define FLI_CTRL_CHANGE_LSB 8
`define FLI_CTRL_CHANGE_MSB 15
`define FLI_CTRL_RST 32'h0000_0000
`define FLI_CHANGE_ERR 8'h01

// slave state codes
`define FLI_ST_BOOT 3'h0
`define FLI_ST_INIT 3'h1
`define FLI_ST_PREOP 3'h2
`define FLI_ST_BOOTSTRAP 3'h3
`define FLI_ST_SAFEOP 3'h4
`define FLI_ST_OP 3'h5
`define FLI_ST_FWDL 3'h6

// error register bits (software raised conditions)
`define FLI_ERR_PDI 0
`define FLI_ERR_CFG 1
`define FLI_ERR_AUTO 2
`define FLI_ERR_APPWD 3

// ======================================================
// timing in ms and the 100 MHz clock rate
`define FLI_CLK_HZ 100000000
`define FLI_TICK_PER_MS (`FLI_CLK_HZ / 1000)
`define FLI_FLICKER_MS 50
`define FLI_FLASH_MS 200
`define FLI_PAUSE_MS 1000
`define FLI_ACT_HOLD_MS 50
`endif

// ===== rtl/fli_pattern.v
// blink pattern generator driven by a 1 ms tick
`timescale 1ns/1ps
module fli_pattern (
    // clock and reset
    input wire CLK,
    input wire NRST,
    // 1 ms tick enable
    input wire ms_tick,
    // pattern levels
    output reg flicker,
    output reg blink,
    output reg single,
    output reg double
);
`include "fli_regs.vh"
    reg [6:0] fl_cnt_q;
    reg [11:0] ph_cnt_q;
    reg [10:0] sg_cnt_q;

    // counters: 100 ms flicker period, 1600 ms double flash frame, 1200 ms single flash frame
    always @(posedge CLK) begin
        if (!NRST) begin
            fl_cnt_q <= 7'h00;
            ph_cnt_q <= 12'h000;
            sg_cnt_q <= 11'h000;
        end else if (ms_tick) begin
            // single flash keeps its own frame so the dark gap stays at the pause length
            if (sg_cnt_q == `FLI_FLASH_MS + `FLI_PAUSE_MS - 1)
                sg_cnt_q <= 11'h000;
            else
                sg_cnt_q <= sg_cnt_q + 11'h001;
            if (fl_cnt_q == 7'd2 * `FLI_FLICKER_MS - 7'd1)
                fl_cnt_q <= 7'h00;
            else
                fl_cnt_q <= fl_cnt_q + 7'h01;
            if (ph_cnt_q == 12'd3 * `FLI_FLASH_MS + `FLI_PAUSE_MS - 12'd1)
                ph_cnt_q <= 12'h000;
            else
                ph_cnt_q <= ph_cnt_q + 12'h001;
        end
    end

    // decode levels into registers
    always @(posedge CLK) begin
        if (!NRST) begin
            flicker <= 1'b0;
            blink <= 1'b0;
            single <= 1'b0;
            double <= 1'b0;
        end else begin
            flicker <= fl_cnt_q < `FLI_FLICKER_MS;
            blink <= ((ph_cnt_q / `FLI_FLASH_MS) % 2) == 0;
            single <= sg_cnt_q < `FLI_FLASH_MS;
            double <= ph_cnt_q < `FLI_FLASH_MS ||
                      (ph_cnt_q >= 2 * `FLI_FLASH_MS && ph_cnt_q < 3 * `FLI_FLASH_MS);
        end
    end
endmodule // fli_pattern

// ===== testbench/fli_checker_assertions.sv
// concurrent checks on the ports of the fieldbus led indicator driver
`timescale 1ns/1ps
module fli_checker #(
    parameter TICK_DIV = 2
) (
    // clock and reset
    input wire CLK,
    input wire NRST,
    // bus handshake
    input wire PSEL,
    input wire PENABLE,
    input wire PREADY,
    input wire PSLVERR,
    // link pins and leds
    input wire PORT_IN_LINK,
    input wire PORT_IN_ACT,
    input wire PORT_OUT_LINK,
    input wire PORT_IN_LINK_INDICATOR,
    input wire PORT_OUT_LINK_INDICATOR,
    // red line and interrupt
    input wire SDA_OE,
    input wire IRQ
);
    int idle_q;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    // ======================================
    // bus handshake, quiet outputs in reset and red line drive
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_access;
        PSEL && PENABLE;
    endsequence
    a_ready_in_access: assert property (s_setup ##1 s_access |-> PREADY)
        else $error("no ready in first access cycle");
    a_ready_one_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    a_error_with_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_reset_quiet: assert property (disable iff (1'b0) !NRST |=> !IRQ && !SDA_OE && !PREADY)
        else $error("outputs active in reset");
    a_sda_driven: assert property ($past(NRST) && NRST |-> SDA_OE)
        else $error("red line not driven");
    // ======================================
    // link indicators
    a_in_link_off: assert property ((!PORT_IN_LINK) [*6] |-> !PORT_IN_LINK_INDICATOR)
        else $error("in led lit without link");
    a_out_link_off: assert property ((!PORT_OUT_LINK) [*6] |-> !PORT_OUT_LINK_INDICATOR)
        else $error("out led lit without link");
    // cycles of valid link without traffic on the in port
    always @(posedge CLK) begin
        idle_q <= (!NRST || !PORT_IN_LINK || PORT_IN_ACT) ? 0 : idle_q + 1;
    end
    a_in_link_steady: assert property (idle_q > 52 * TICK_DIV + 6 |-> PORT_IN_LINK_INDICATOR)
        else $error("idle link led not lit");
endmodule // fli_checker

bind fli_top fli_checker #(.TICK_DIV(TICK_DIV)) u_chk (.CLK, .NRST, .PSEL, .PENABLE,
    .PREADY, .PSLVERR, .PORT_IN_LINK, .PORT_IN_ACT, .PORT_OUT_LINK,
    .PORT_IN_LINK_INDICATOR, .PORT_OUT_LINK_INDICATOR, .SDA_OE, .IRQ);

// ===== testbench/fli_led_mon.sv
// led model timing the lit and dark runs of one indicator
`timescale 1ns/1ps
module fli_led_mon (
    // clock
    input wire CLK,
    // led level, high is lit
    input wire led,
    // last lit run, last two dark runs, current run
    output int on_len,
    output int off_len,
    output int off_prev,
    output int run
);
    logic last_q = 1'b0;
    // close a run at each change of the led level
    always @(posedge CLK) begin
        last_q <= led;
        if (led !== last_q) begin
            run <= 1;
            if (last_q) on_len <= run;
            else begin
                off_prev <= off_len;
                off_len <= run;
            end
        end else begin
            run <= run + 1;
        end
    end
endmodule // fli_led_mon

// ===== testbench/tb_top.sv
// self-checking bench for the fieldbus led indicator driver
`timescale 1ns/1ps
`include "fli_regs.vh"
module tb_top;
    logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, e;
    logic [11:0] padr = 0;
    logic [31:0] pwd = 0, prd, q;
    logic rdy, serr, irq, sda_o, sda_oe, st_led, in_led, out_led;
    logic in_l = 0, in_a = 0, out_l = 0, out_a = 0;
    wire sda_w = sda_oe ? sda_o : 1'b1;
    int n_fail = 0, n_checks = 0, cyc = 0, k, t;
    // ======================================
    // clock, design and led models
    initial forever #5 clk = ~clk;
    fli_top #(.TICK_DIV(2)) u_dut (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy),
        .PSLVERR(serr), .PORT_IN_LINK(in_l), .PORT_IN_ACT(in_a), .PORT_OUT_LINK(out_l),
        .PORT_OUT_ACT(out_a), .PORT_IN_LINK_INDICATOR(in_led),
        .PORT_OUT_LINK_INDICATOR(out_led), .STATE_INDICATOR(st_led), .SDA_I(sda_w),
        .SDA_O(sda_o), .SDA_OE(sda_oe), .IRQ(irq));
    fli_led_mon u_g (.CLK(clk), .led(st_led), .on_len(), .off_len(), .off_prev(), .run());
    fli_led_mon u_r (.CLK(clk), .led(sda_w), .on_len(), .off_len(), .off_prev(), .run());
    // ======================================
    // tasks
    task give_verdict();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task ck(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        q = prd;
        e = serr;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(0, a, 0);
        ck(q === x && e === 1'b0, "read value");
    endtask
    task wirq(input logic v);
        int i;
        for (i = 0; i < 8 && irq !== v; i++) @(posedge clk);
        ck(irq === v, "irq level");
    endtask
    // lengths in ms; no lit time means dark, no dark time means lit
    task pat(input bit r, input int on, off, prv);
        int a, b, c, n;
        logic v;
        a = r ? u_r.on_len : u_g.on_len;
        b = r ? u_r.off_len : u_g.off_len;
        c = r ? u_r.off_prev : u_g.off_prev;
        n = r ? u_r.run : u_g.run;
        v = r ? sda_w : st_led;
        if (on == 0 || off == 0) ck(n > 4000 && v === (on != 0), "steady led");
        else ck(a == 2 * on && (b == 2 * off && c == 2 * prv
            || b == 2 * prv && c == 2 * off), "led pattern");
    endtask
    task step(input logic [2:0] s, input logic [7:0] c, input logic [3:0] r,
              input int g0, g1, g2, r0, r1, r2);
        apb(1, `FLI_CTRL_OFF, {16'h0000, c, 5'h00, s});
        apb(1, `FLI_ERR_OFF, {28'h000_0000, r});
        repeat (8000) @(posedge clk);
        pat(0, g0, g1, g2);
        pat(1, r0, r1, r2);
        $display("test state %0d err %0h done", s, r);
    endtask
    // ======================================
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            n_fail++;
            give_verdict();
        end
    end
    // ======================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1;
        rd(`FLI_CTRL_OFF, `FLI_CTRL_RST);
        apb(0, 12'h020, 0);
        ck(q === 0 && e === 1'b1, "unmapped");
        apb(1, `FLI_MASK_OFF, 1);
        apb(1, `FLI_ERR_OFF, 1);
        wirq(1);
        apb(1, `FLI_IRQ_OFF, 1);
        wirq(0);
        apb(1, `FLI_ERR_OFF, 2);
        rd(`FLI_IRQ_OFF, 2);
        wirq(0);
        apb(1, `FLI_MASK_OFF, 3);
        wirq(1);
        apb(1, `FLI_IRQ_OFF, 2);
        wirq(0);
        $display("test registers done");
        in_l <= 1;
        repeat (140) @(posedge clk);
        ck(in_led === 1'b1 && out_led === 1'b0, "in link");
        in_l <= 0;
        out_l <= 1;
        repeat (140) @(posedge clk);
        ck(in_led === 1'b0 && out_led === 1'b1, "out link");
        t = 0;
        for (k = 0; k < 400; k++) begin
            out_a <= k[3];
            @(posedge clk);
            t += out_led;
        end
        ck(t > 0 && t < 400, "activity flicker");
        $display("test links done");
        step(`FLI_ST_INIT, 0, 0, 0, 0, 0, 0, 0, 0);
        step(`FLI_ST_OP, 0, 1, 1, 0, 0, 1, 0, 0);
        rd(`FLI_STAT_OFF, 32'h0000_003C);
        step(`FLI_ST_PREOP, 0, 2, 200, 200, 200, 200, 200, 200);
        step(`FLI_ST_BOOT, 0, 0, 50, 50, 50, 0, 0, 0);
        step(`FLI_ST_INIT, `FLI_CHANGE_ERR, 0, 0, 0, 0, 50, 50, 50);
        step(`FLI_ST_SAFEOP, `FLI_CHANGE_ERR, 0, 200, 1000, 1000, 200, 1000, 1000);
        step(`FLI_ST_BOOTSTRAP, 0, 4'hA, 50, 50, 50, 200, 200, 1000);
        step(`FLI_ST_FWDL, 0, 4'hF, 50, 50, 50, 1, 0, 0);
        give_verdict();
    end
endmodule // tb_top
